//--- sim/cmwls_ic_model.sv
// Behavioural interconnect answering the tracker's address channels
module cmwls_ic_model (
  input wire clk,
  input wire nrst,
  input wire slow,
  input wire bad_resp,
  input wire rd_addr_valid,
  input wire wr_addr_valid,
  output reg rd_addr_ready,
  output reg wr_addr_ready,
  output reg rd_resp_valid,
  output reg rd_resp_shared,
  output reg rd_resp_pass_dirty,
  output reg wr_resp_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  reg rd;
  initial begin
    {rd_addr_ready, wr_addr_ready, rd_resp_valid, wr_resp_valid} = 4'h0;
    {rd_resp_shared, rd_resp_pass_dirty} = 2'h3;
    forever begin
      @(posedge clk);
      #1;
      if (nrst && (rd_addr_valid || wr_addr_valid)) begin
        rd = rd_addr_valid;
        repeat (slow ? 3 : 0) @(posedge clk);
        #1;
        rd_addr_ready = rd;
        wr_addr_ready = !rd;
        @(posedge clk);
        #1;
        {rd_addr_ready, wr_addr_ready} = 2'h0;
        repeat (slow ? 4 : 1) @(posedge clk);
        #1;
        rd_resp_valid = rd;
        wr_resp_valid = !rd;
        rd_resp_shared = bad_resp;
        rd_resp_pass_dirty = 1'b0;
        @(posedge clk);
        #1;
        {rd_resp_valid, wr_resp_valid} = 2'h0;
        // Stale bits flip so a late sample cannot pass
        rd_resp_shared = !rd_resp_shared;
        rd_resp_pass_dirty = 1'b1;
      end
    end
  end
endmodule // cmwls_ic_model

//--- sim/cmwls_tracker_sva.sv
// Port checker for the line-state tracker
`include "cmwls_map.vh"
module cmwls_tracker_sva (
  input wire REF_CLK,
  input wire NRST,
  input wire WB_PENDING,
  input wire WB_BLOCK,
  input wire RD_ADDR_VALID,
  input wire WR_ADDR_VALID,
  input wire [`CMWLS_OP_W-1:0] ADDR_OP,
  input wire ADDR_SHAREABLE,
  input wire [`CMWLS_STRB_W-1:0] WR_STROBE,
  input wire DONE,
  input wire [`CMWLS_ST_W-1:0] DONE_STATE,
  input wire ERR
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  wire mk = ADDR_OP == `CMWLS_OP_MAKE_UNIQUE;
  wire ns = ADDR_OP == `CMWLS_OP_WRITE_NO_SNOOP;
  wire wu = ADDR_OP == `CMWLS_OP_WRITE_UNIQUE;
  wire uq = wu || ADDR_OP == `CMWLS_OP_WRITE_LINE_UNIQUE;
  wire good = DONE && !ERR;
  property p_rd_op; RD_ADDR_VALID |-> ADDR_OP <= `CMWLS_OP_MAKE_INVALID; endproperty
  a_rd_op: assert property (p_rd_op) else $error("write op on read channel");
  property p_wr_op; WR_ADDR_VALID |-> ns || uq; endproperty
  a_wr_op: assert property (p_wr_op) else $error("make op on write channel");
  property p_one_ch; !(RD_ADDR_VALID && WR_ADDR_VALID); endproperty
  a_one_ch: assert property (p_one_ch) else $error("both channels valid");
  property p_mu_go; RD_ADDR_VALID && mk |-> ADDR_SHAREABLE && WR_STROBE == `CMWLS_STRB_FULL;
  endproperty
  a_mu_go: assert property (p_mu_go) else $error("make unique issued wrongly");
  property p_ns_go; WR_ADDR_VALID && ns |-> !ADDR_SHAREABLE; endproperty
  a_ns_go: assert property (p_ns_go) else $error("no-snoop write to shared");
  property p_uq_go; WR_ADDR_VALID && uq |->
    ADDR_SHAREABLE && WB_BLOCK && (wu || WR_STROBE == `CMWLS_STRB_FULL); endproperty
  a_uq_go: assert property (p_uq_go) else $error("unique write issued wrongly");
  property p_wb_wait; $rose(WR_ADDR_VALID) && uq |-> $past(WB_PENDING) == 1'b0; endproperty
  a_wb_wait: assert property (p_wb_wait) else $error("unique write before drain");
  property p_mu_end; good && mk |-> DONE_STATE inside {`CMWLS_ST_UD, `CMWLS_ST_SD}; endproperty
  a_mu_end: assert property (p_mu_end) else $error("make unique end state");
  property p_mi_end; good && ADDR_OP == `CMWLS_OP_MAKE_INVALID |-> DONE_STATE == `CMWLS_ST_I;
  endproperty
  a_mi_end: assert property (p_mi_end) else $error("make invalid end state");
  property p_ns_end; good && ns |->
    DONE_STATE inside {`CMWLS_ST_I, `CMWLS_ST_UC, `CMWLS_ST_SC}; endproperty
  a_ns_end: assert property (p_ns_end) else $error("no-snoop end state");
  property p_uq_end; good && uq |-> DONE_STATE inside {`CMWLS_ST_I, `CMWLS_ST_SC}; endproperty
  a_uq_end: assert property (p_uq_end) else $error("unique write end state");
  property p_err; ERR |-> DONE ##1 !DONE; endproperty
  a_err: assert property (p_err) else $error("error without done pulse");
endmodule // cmwls_tracker_sva

bind cmwls_tracker cmwls_tracker_sva cmwls_tracker_sva_inst (.REF_CLK(REF_CLK), .NRST(NRST),
  .WB_PENDING(WB_PENDING), .WB_BLOCK(WB_BLOCK), .RD_ADDR_VALID(RD_ADDR_VALID),
  .WR_ADDR_VALID(WR_ADDR_VALID), .ADDR_OP(ADDR_OP), .ADDR_SHAREABLE(ADDR_SHAREABLE),
  .WR_STROBE(WR_STROBE), .DONE(DONE), .DONE_STATE(DONE_STATE), .ERR(ERR));

//--- sim/testbench.sv
// Self-checking bench for the line-state tracker
`include "cmwls_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [2:0] mu = 3'h0, mi = 3'h1, wns = 3'h2, wu = 3'h3, wlu = 3'h4;
  localparam [2:0] s_i = 3'h0, s_uc = 3'h1, s_ud = 3'h2, s_sc = 3'h3, s_sd = 3'h4;
  localparam [3:0] f = `CMWLS_STRB_FULL;
  reg ref_clk = 0, nrst = 0, sf = 0, req_valid = 0, sh = 0, alt_en = 0;
  reg wb_pend = 0, bad = 0, slow = 0;
  reg [2:0] op = 0, alt_st = 0;
  reg [3:0] idx = 0, strb = 0;
  reg [31:0] data = 0, seed = 32'hae0f;
  reg [5:0] ent;
  wire ready, done, err, rd_av, rd_ar, wr_av, wr_ar, rd_rv, rd_sh, rd_pd, wr_rv, wb_block;
  wire [2:0] done_st, err_code;
  wire [2:0] a_op;
  wire [3:0] a_idx, a_strb;
  wire a_sh;
  wire [31:0] a_data;
  logic [5:0] expq[$];
  integer err_total = 0, comparisons = 0;
  always #20 ref_clk = ~ref_clk;
  cmwls_tracker cmwls_tracker_inst (.REF_CLK(ref_clk), .NRST(nrst), .CE(1'b1),
    .SNOOP_FILTER(sf), .REQ_VALID(req_valid), .REQ_OP(op), .REQ_INDEX(idx),
    .REQ_SHAREABLE(sh), .REQ_DATA(data), .REQ_STROBE(strb), .REQ_ALT_EN(alt_en),
    .REQ_ALT_STATE(alt_st), .REQ_READY(ready), .DONE(done), .DONE_STATE(done_st),
    .ERR(err), .ERR_CODE(err_code), .WB_PENDING(wb_pend), .WB_BLOCK(wb_block),
    .RD_ADDR_VALID(rd_av), .RD_ADDR_READY(rd_ar), .WR_ADDR_VALID(wr_av),
    .WR_ADDR_READY(wr_ar), .ADDR_OP(a_op), .ADDR_INDEX(a_idx), .ADDR_SHAREABLE(a_sh),
    .WR_DATA(a_data), .WR_STROBE(a_strb), .RD_RESP_VALID(rd_rv), .RD_RESP_SHARED(rd_sh),
    .RD_RESP_PASS_DIRTY(rd_pd), .WR_RESP_VALID(wr_rv));
  cmwls_ic_model cmwls_ic_model_inst (.clk(ref_clk), .nrst(nrst), .slow(slow),
    .bad_resp(bad), .rd_addr_valid(rd_av), .wr_addr_valid(wr_av), .rd_addr_ready(rd_ar),
    .wr_addr_ready(wr_ar), .rd_resp_valid(rd_rv), .rd_resp_shared(rd_sh),
    .rd_resp_pass_dirty(rd_pd), .wr_resp_valid(wr_rv));
  function automatic [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task automatic check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task automatic end_sim;
    begin
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task automatic req(input [2:0] o, input [3:0] i, input s, input [3:0] st, input ae,
    input [2:0] as, input b, input [2:0] es, input [2:0] ec);
    integer n;
    begin
      seed = xs(seed);
      @(posedge ref_clk);
      #1;
      {op, idx, sh, strb, alt_en, alt_st, bad} = {o, i, s, st, ae, as, b};
      data = seed;
      slow = seed[8];
      expq.push_back({es, ec});
      req_valid = 1;
      @(posedge ref_clk);
      #1;
      req_valid = 0;
      n = 0;
      while (ready !== 1'b1 && n < 400) begin
        @(posedge ref_clk);
        #1;
        n = n + 1;
      end
      if (n == 400) err_total = err_total + 1;
    end
  endtask
  // Expected results queue in order; one request outstanding at a time
  always @(posedge ref_clk) begin
    if (nrst && done === 1'b1) begin
      if (expq.size() == 0) err_total = err_total + 1;
      else begin
        ent = expq.pop_front();
        check(done_st, ent[5:3]);
        check(err, ent[2:0] != 0);
        if (ent[2:0] != 0) check(err_code, ent[2:0]);
      end
    end
    // Channel payload must match the held request while valid stands
    if (nrst && (rd_av === 1'b1 || wr_av === 1'b1)) begin
      check({a_op, a_idx, a_sh, a_strb}, {op, idx, sh, strb});
      check(a_data, data);
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    nrst = 1;
    repeat (2) @(posedge ref_clk);
    req(mu, 1, 1, f, 0, 0, 0, s_ud, 0);
    req(wu, 1, 1, f, 0, 0, 0, s_ud, 3);
    req(wns, 1, 0, f, 0, 0, 0, s_uc, 0);
    wb_pend = 1;
    fork
      begin
        repeat (8) @(posedge ref_clk);
        #1;
        check(wr_av, 0);
        check(wb_block, 1);
        check(ready, 0);
        wb_pend = 0;
      end
    join_none
    req(wu, 1, 1, f, 0, 0, 0, s_sc, 0);
    check(cmwls_tracker_inst.u_mem.data_mem[1], data);
    check(wb_block, 0);
    req(wlu, 1, 1, 4'h7, 0, 0, 0, s_sc, 2);
    req(wlu, 1, 1, f, 0, 0, 0, s_sc, 0);
    check(cmwls_tracker_inst.u_mem.data_mem[1], data);
    req(mi, 1, 0, f, 0, 0, 0, s_i, 0);
    req(mu, 2, 0, f, 0, 0, 0, s_i, 1);
    req(mu, 2, 1, 4'h3, 0, 0, 0, s_i, 2);
    req(mu, 2, 1, f, 0, 0, 1, s_i, 4);
    req(wu, 2, 1, f, 0, 0, 0, s_i, 0);
    req(3'h5, 2, 1, f, 0, 0, 0, s_i, 6);
    req(wns, 4, 0, 4'h1, 1, s_uc, 0, s_i, 5);
    req(wns, 4, 0, f, 1, s_uc, 0, s_uc, 0);
    req(wu, 4, 0, f, 0, 0, 0, s_uc, 1);
    req(mu, 4, 1, f, 1, s_sd, 0, s_sd, 0);
    req(wns, 4, 1, f, 0, 0, 0, s_sd, 1);
    req(wns, 4, 0, f, 0, 0, 0, s_uc, 0);
    sf = 1;
    repeat (4) @(posedge ref_clk);
    req(wlu, 4, 1, f, 1, s_i, 0, s_sc, 5);
    sf = 0;
    repeat (4) @(posedge ref_clk);
    req(wu, 4, 1, f, 1, s_i, 0, s_i, 0);
    repeat (5) @(posedge ref_clk);
    check(expq.size(), 0);
    end_sim;
  end
  initial begin
    #2000000;
    err_total = err_total + 1;
    end_sim;
  end
endmodule // testbench

//--- verilog/cmwls_line_mem.v
// Line state and data store with registered read port
`include "cmwls_map.vh"

module cmwls_line_mem (
  input wire clk,
  input wire nrst,
  input wire ce,
  input wire we,
  input wire [`CMWLS_IDX_W-1:0] waddr,
  input wire [`CMWLS_ST_W-1:0] wstate,
  input wire [`CMWLS_DATA_W-1:0] wdata,
  input wire [`CMWLS_IDX_W-1:0] raddr,
  output reg [`CMWLS_ST_W-1:0] rstate,
  output reg [`CMWLS_DATA_W-1:0] rdata
);
  reg [`CMWLS_ST_W-1:0] state_mem [0:`CMWLS_LINES-1];
  reg [`CMWLS_DATA_W-1:0] data_mem [0:`CMWLS_LINES-1];
  integer i;

  // States reset so every line starts Invalid; data needs no reset
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < `CMWLS_LINES; i = i + 1) begin
        state_mem[i] <= `CMWLS_ST_RESET;
      end
      rstate <= `CMWLS_ST_RESET;
    end else if (ce) begin
      if (we) begin
        state_mem[waddr] <= wstate;
      end
      rstate <= state_mem[raddr];
    end
  end

  always @(posedge clk) begin
    if (ce) begin
      if (we) begin
        data_mem[waddr] <= wdata;
      end
      rdata <= data_mem[raddr];
    end
  end
endmodule // cmwls_line_mem

//--- verilog/cmwls_map.vh
// Constants for the coherent make and write line-state tracker
`ifndef CMWLS_MAP_VH
`define CMWLS_MAP_VH

// Transaction codes on the user request and the address channels
`define CMWLS_OP_W 3
`define CMWLS_OP_MAKE_UNIQUE 3'h0
`define CMWLS_OP_MAKE_INVALID 3'h1
`define CMWLS_OP_WRITE_NO_SNOOP 3'h2
`define CMWLS_OP_WRITE_UNIQUE 3'h3
`define CMWLS_OP_WRITE_LINE_UNIQUE 3'h4

// Cache line states
`define CMWLS_ST_W 3
`define CMWLS_ST_I 3'h0
`define CMWLS_ST_UC 3'h1
`define CMWLS_ST_UD 3'h2
`define CMWLS_ST_SC 3'h3
`define CMWLS_ST_SD 3'h4
`define CMWLS_ST_RESET 3'h0

// Line store geometry: one word per line
`define CMWLS_IDX_W 4
`define CMWLS_LINES 16
`define CMWLS_DATA_W 32
`define CMWLS_STRB_W 4
`define CMWLS_STRB_FULL 4'hf

// Response bits shared and pass-dirty, both must be clear for Make
`define CMWLS_RESP_CLEAN 2'h0

// Error codes reported with completion
`define CMWLS_ERR_W 3
`define CMWLS_ERR_NONE 3'h0
`define CMWLS_ERR_REGION 3'h1
`define CMWLS_ERR_PARTIAL 3'h2
`define CMWLS_ERR_DIRTY 3'h3
`define CMWLS_ERR_RESP 3'h4
`define CMWLS_ERR_END 3'h5
`define CMWLS_ERR_OP 3'h6

`endif

//--- verilog/cmwls_tracker.v
// Master-side line-state tracker for Make and Write coherent transactions
`include "cmwls_map.vh"

// Overview of operation
// R1: Make requests go out on read address, Write requests on write address.
// R2: MakeUnique only for shareable memory; ends Unique, no data, other copies gone.
// R3: MakeUnique is accepted only together with a full-line store.
// R4: Interconnect answers MakeUnique with shared and pass-dirty both clear.
// R5: MakeUnique with full store ends UD; only UD or SD are legal.
// R6: MakeInvalid is a broadcast invalidate in shareable or non-shareable memory.
// R7: A valid local copy is invalidated before MakeInvalid is issued.
// R8: MakeInvalid starts I, answer bits clear, ends I always.
// R9: WriteNoSnoop only for non-shareable memory.
// R10: WriteNoSnoop keeps I, dirty or shared lines become UC; I, UC, SC legal.
// R11: A line leaves Invalid only after a full-line store.
// R12: WriteUnique only for shareable memory, single write to main memory.
// R13: WriteUnique keeps I, UC/SC end SC; snoop filter allows only SC.
// R14: Clean holder updates its copy when the WriteUnique response arrives.
// R15: WriteLineUnique only shareable and with every byte strobed.
// R16: WriteLineUnique keeps I, UC/SC end SC; snoop filter allows only SC.
// R17: Clean holder updates its copy when the WriteLineUnique response arrives.
// R18: Write-backs drain before unique writes; none start until they complete.
// R19: Bad response bits or illegal end states are reported as errors.
module cmwls_tracker (
  input wire REF_CLK,
  input wire NRST,
  input wire CE,
  input wire SNOOP_FILTER,
  input wire REQ_VALID,
  input wire [`CMWLS_OP_W-1:0] REQ_OP,
  input wire [`CMWLS_IDX_W-1:0] REQ_INDEX,
  input wire REQ_SHAREABLE,
  input wire [`CMWLS_DATA_W-1:0] REQ_DATA,
  input wire [`CMWLS_STRB_W-1:0] REQ_STROBE,
  input wire REQ_ALT_EN,
  input wire [`CMWLS_ST_W-1:0] REQ_ALT_STATE,
  output reg REQ_READY,
  output reg DONE,
  output reg [`CMWLS_ST_W-1:0] DONE_STATE,
  output reg ERR,
  output reg [`CMWLS_ERR_W-1:0] ERR_CODE,
  input wire WB_PENDING,
  output reg WB_BLOCK,
  output reg RD_ADDR_VALID,
  input wire RD_ADDR_READY,
  output reg WR_ADDR_VALID,
  input wire WR_ADDR_READY,
  output reg [`CMWLS_OP_W-1:0] ADDR_OP,
  output reg [`CMWLS_IDX_W-1:0] ADDR_INDEX,
  output reg ADDR_SHAREABLE,
  output reg [`CMWLS_DATA_W-1:0] WR_DATA,
  output reg [`CMWLS_STRB_W-1:0] WR_STROBE,
  input wire RD_RESP_VALID,
  input wire RD_RESP_SHARED,
  input wire RD_RESP_PASS_DIRTY,
  input wire WR_RESP_VALID
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_LOOK = 3'h1;
  localparam [2:0] S_WAIT_WB = 3'h2;
  localparam [2:0] S_ISSUE = 3'h3;
  localparam [2:0] S_WAIT = 3'h4;

  function is_make;
    input [`CMWLS_OP_W-1:0] op;
    begin
      is_make = (op == `CMWLS_OP_MAKE_UNIQUE) || (op == `CMWLS_OP_MAKE_INVALID);
    end
  endfunction

  function is_uniq_wr;
    input [`CMWLS_OP_W-1:0] op;
    begin
      is_uniq_wr = (op == `CMWLS_OP_WRITE_UNIQUE) || (op == `CMWLS_OP_WRITE_LINE_UNIQUE);
    end
  endfunction

  function is_dirty;
    input [`CMWLS_ST_W-1:0] st;
    begin
      is_dirty = (st == `CMWLS_ST_UD) || (st == `CMWLS_ST_SD);
    end
  endfunction

  // Expected end state of each transaction
  function [`CMWLS_ST_W-1:0] expect_end;
    input [`CMWLS_OP_W-1:0] op;
    input [`CMWLS_ST_W-1:0] st;
    begin
      case (op)
        `CMWLS_OP_MAKE_UNIQUE: expect_end = `CMWLS_ST_UD; // [R5]
        `CMWLS_OP_MAKE_INVALID: expect_end = `CMWLS_ST_I; // [R8]
        `CMWLS_OP_WRITE_NO_SNOOP: begin
          expect_end = (st == `CMWLS_ST_I) ? `CMWLS_ST_I : `CMWLS_ST_UC; // [R10]
        end
        default: begin
          expect_end = (st == `CMWLS_ST_I) ? `CMWLS_ST_I : `CMWLS_ST_SC; // [R13] [R16]
        end
      endcase
    end
  endfunction

  // Legal end states per transaction, start state and snoop-filter setting
  function legal_end;
    input [`CMWLS_OP_W-1:0] op;
    input [`CMWLS_ST_W-1:0] st;
    input [`CMWLS_ST_W-1:0] en;
    input sf;
    input full;
    begin
      case (op)
        `CMWLS_OP_MAKE_UNIQUE: begin
          legal_end = (en == `CMWLS_ST_UD) || (en == `CMWLS_ST_SD); // [R5]
        end
        `CMWLS_OP_MAKE_INVALID: legal_end = (en == `CMWLS_ST_I); // [R8]
        `CMWLS_OP_WRITE_NO_SNOOP: begin
          legal_end = (en == `CMWLS_ST_I) ||
                      (((en == `CMWLS_ST_UC) || (en == `CMWLS_ST_SC)) &&
                       ((st != `CMWLS_ST_I) || full)); // [R10] [R11]
        end
        `CMWLS_OP_WRITE_UNIQUE, `CMWLS_OP_WRITE_LINE_UNIQUE: begin
          if (st == `CMWLS_ST_I) begin
            legal_end = (en == `CMWLS_ST_I);
          end else begin
            legal_end = (en == `CMWLS_ST_SC) || (!sf && (en == `CMWLS_ST_I)); // [R13] [R16]
          end
        end
        default: legal_end = 1'b0;
      endcase
    end
  endfunction

  function [`CMWLS_DATA_W-1:0] merge;
    input [`CMWLS_DATA_W-1:0] old_d;
    input [`CMWLS_DATA_W-1:0] new_d;
    input [`CMWLS_STRB_W-1:0] strb;
    integer b;
    begin
      merge = old_d;
      for (b = 0; b < `CMWLS_STRB_W; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = new_d[b*8 +: 8];
        end
      end
    end
  endfunction

  reg sf_meta_reg;
  reg sf_reg;
  reg [2:0] state_reg, state_next;
  reg [`CMWLS_ST_W-1:0] start_reg, start_next;
  reg [`CMWLS_DATA_W-1:0] old_data_reg, old_data_next;
  reg alt_en_reg;
  reg [`CMWLS_ST_W-1:0] alt_st_reg;
  reg [`CMWLS_ERR_W-1:0] look_err;
  reg [`CMWLS_ST_W-1:0] end_st;
  reg [`CMWLS_ERR_W-1:0] fin_err;
  reg resp_hit;
  reg mem_we;
  reg [`CMWLS_ST_W-1:0] mem_wstate;
  reg [`CMWLS_DATA_W-1:0] mem_wdata;
  wire [`CMWLS_ST_W-1:0] mem_rstate;
  wire [`CMWLS_DATA_W-1:0] mem_rdata;
  wire full_line;
  wire addr_taken;

  assign full_line = (WR_STROBE == `CMWLS_STRB_FULL);
  assign addr_taken = (RD_ADDR_VALID && RD_ADDR_READY) || (WR_ADDR_VALID && WR_ADDR_READY);

  cmwls_line_mem u_mem (
    .clk(REF_CLK),
    .nrst(NRST),
    .ce(CE),
    .we(mem_we),
    .waddr(ADDR_INDEX),
    .wstate(mem_wstate),
    .wdata(mem_wdata),
    .raddr(REQ_INDEX),
    .rstate(mem_rstate),
    .rdata(mem_rdata)
  );

  // Look-up checks on the captured request and the stored start state
  always @* begin
    look_err = `CMWLS_ERR_NONE;
    case (ADDR_OP)
      `CMWLS_OP_MAKE_UNIQUE: begin
        if (!ADDR_SHAREABLE) look_err = `CMWLS_ERR_REGION; // [R2]
        else if (!full_line) look_err = `CMWLS_ERR_PARTIAL; // [R3]
      end
      `CMWLS_OP_MAKE_INVALID: look_err = `CMWLS_ERR_NONE; // [R6]
      `CMWLS_OP_WRITE_NO_SNOOP: begin
        if (ADDR_SHAREABLE) look_err = `CMWLS_ERR_REGION; // [R9]
      end
      `CMWLS_OP_WRITE_UNIQUE: begin
        if (!ADDR_SHAREABLE) look_err = `CMWLS_ERR_REGION; // [R12]
        else if (is_dirty(mem_rstate)) look_err = `CMWLS_ERR_DIRTY;
      end
      `CMWLS_OP_WRITE_LINE_UNIQUE: begin
        if (!ADDR_SHAREABLE) look_err = `CMWLS_ERR_REGION; // [R15]
        else if (!full_line) look_err = `CMWLS_ERR_PARTIAL; // [R15]
        else if (is_dirty(mem_rstate)) look_err = `CMWLS_ERR_DIRTY;
      end
      default: look_err = `CMWLS_ERR_OP;
    endcase
  end

  // Completion: pick end state, check answer bits and legality
  always @* begin
    resp_hit = is_make(ADDR_OP) ? RD_RESP_VALID : WR_RESP_VALID;
    fin_err = `CMWLS_ERR_NONE;
    end_st = expect_end(ADDR_OP, start_reg);
    if (is_make(ADDR_OP) &&
        ({RD_RESP_SHARED, RD_RESP_PASS_DIRTY} != `CMWLS_RESP_CLEAN)) begin
      fin_err = `CMWLS_ERR_RESP; // [R4] [R8] [R19]
      end_st = start_reg;
    end else if (alt_en_reg) begin
      if (legal_end(ADDR_OP, start_reg, alt_st_reg, sf_reg, full_line)) begin
        end_st = alt_st_reg;
      end else begin
        fin_err = `CMWLS_ERR_END; // [R19]
      end
    end
  end

  always @* begin
    state_next = state_reg;
    start_next = start_reg;
    old_data_next = old_data_reg;
    mem_we = 1'b0;
    mem_wstate = `CMWLS_ST_I;
    mem_wdata = old_data_reg;
    case (state_reg)
      S_IDLE: begin
        if (REQ_VALID) state_next = S_LOOK;
      end
      S_LOOK: begin
        start_next = mem_rstate;
        old_data_next = mem_rdata;
        if (look_err != `CMWLS_ERR_NONE) begin
          state_next = S_IDLE;
        end else if (ADDR_OP == `CMWLS_OP_MAKE_INVALID) begin
          // Own copy dropped first so the broadcast starts from Invalid
          mem_we = (mem_rstate != `CMWLS_ST_I); // [R7]
          mem_wdata = mem_rdata;
          start_next = `CMWLS_ST_I; // [R7]
          state_next = S_ISSUE;
        end else if (is_uniq_wr(ADDR_OP) && WB_PENDING) begin
          state_next = S_WAIT_WB; // [R18]
        end else begin
          state_next = S_ISSUE;
        end
      end
      S_WAIT_WB: begin
        if (!WB_PENDING) state_next = S_ISSUE; // [R18]
      end
      S_ISSUE: begin
        if (addr_taken) state_next = S_WAIT;
      end
      S_WAIT: begin
        if (resp_hit) begin
          state_next = S_IDLE;
          mem_we = 1'b1;
          mem_wstate = end_st;
          // Store coupled to the response: a stale copy is never visible
          if ((ADDR_OP == `CMWLS_OP_MAKE_UNIQUE) || (end_st != `CMWLS_ST_I)) begin
            mem_wdata = merge(old_data_reg, WR_DATA, WR_STROBE); // [R2] [R14] [R17]
          end
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      sf_meta_reg <= 1'b0;
      sf_reg <= 1'b0;
      state_reg <= S_IDLE;
      start_reg <= `CMWLS_ST_I;
      old_data_reg <= 32'h0;
      alt_en_reg <= 1'b0;
      alt_st_reg <= `CMWLS_ST_I;
      REQ_READY <= 1'b0;
      DONE <= 1'b0;
      DONE_STATE <= `CMWLS_ST_I;
      ERR <= 1'b0;
      ERR_CODE <= `CMWLS_ERR_NONE;
      WB_BLOCK <= 1'b0;
      RD_ADDR_VALID <= 1'b0;
      WR_ADDR_VALID <= 1'b0;
      ADDR_OP <= `CMWLS_OP_MAKE_UNIQUE;
      ADDR_INDEX <= 4'h0;
      ADDR_SHAREABLE <= 1'b0;
      WR_DATA <= 32'h0;
      WR_STROBE <= 4'h0;
    end else if (CE) begin
      sf_meta_reg <= SNOOP_FILTER;
      sf_reg <= sf_meta_reg;
      state_reg <= state_next;
      start_reg <= start_next;
      old_data_reg <= old_data_next;
      REQ_READY <= (state_next == S_IDLE);
      DONE <= 1'b0;
      ERR <= 1'b0;
      if ((state_reg == S_IDLE) && REQ_VALID) begin
        ADDR_OP <= REQ_OP;
        ADDR_INDEX <= REQ_INDEX;
        ADDR_SHAREABLE <= REQ_SHAREABLE;
        WR_DATA <= REQ_DATA;
        WR_STROBE <= REQ_STROBE;
        alt_en_reg <= REQ_ALT_EN;
        alt_st_reg <= REQ_ALT_STATE;
      end
      if ((state_reg == S_LOOK) && (look_err != `CMWLS_ERR_NONE)) begin
        DONE <= 1'b1;
        DONE_STATE <= mem_rstate;
        ERR <= 1'b1;
        ERR_CODE <= look_err;
      end
      // Unique writes hold off new write-backs until they complete
      if ((state_reg == S_LOOK) && (state_next != S_IDLE) && is_uniq_wr(ADDR_OP)) begin
        WB_BLOCK <= 1'b1; // [R18]
      end
      if ((state_reg != S_ISSUE) && (state_next == S_ISSUE)) begin
        RD_ADDR_VALID <= is_make(ADDR_OP); // [R1]
        WR_ADDR_VALID <= !is_make(ADDR_OP); // [R1]
      end else if (addr_taken) begin
        RD_ADDR_VALID <= 1'b0;
        WR_ADDR_VALID <= 1'b0;
      end
      if ((state_reg == S_WAIT) && resp_hit) begin
        DONE <= 1'b1;
        DONE_STATE <= end_st;
        ERR <= (fin_err != `CMWLS_ERR_NONE);
        ERR_CODE <= fin_err;
        WB_BLOCK <= 1'b0;
      end
    end
  end
endmodule // cmwls_tracker
